// ===== atc_comparator.sv
`timescale 1ns/10ps
`include "atc_map.svh"

module atc_comparator
  import atc_pkg::*;
#(
  parameter int MS_CYCLES = `ATC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic      CLK,
  input  wire logic      RST_B,
  // Measured quantities
  input  wire logic      POSITIVE_INPUT_SELECT,
  input  wire atc_meas_t POSITIVE_INPUT,
  input  wire logic      NEGATIVE_INPUT_SELECT,
  input  wire atc_meas_t NEGATIVE_INPUT,
  // Settings
  input  wire atc_cfg_t  CFG,
  // Results
  output logic           FLAG,
  output logic           PICKUP,
  output logic           INHIBITED
);

  localparam int VW = `ATC_VAL_W;
  localparam int CW = 2 * VW + 2;
  localparam int FR = `ATC_PU_FRAC;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end
  if (VW != 32) begin : g_bad_vw
    $error("Value width must match package fields");
  end

  // ****************************************************************
  // Input selection and validity
  // ****************************************************************
  logic signed [VW:0]    pos_v;
  logic signed [VW:0]    neg_v;
  logic                  both_off;
  logic                  kind_clash;
  logic                  inhibit_w;
  atc_kind_t             kind_w;

  assign pos_v = POSITIVE_INPUT_SELECT ?
                 (VW+1)'(POSITIVE_INPUT.value) : '0;
  assign neg_v = NEGATIVE_INPUT_SELECT ?
                 (VW+1)'(NEGATIVE_INPUT.value) : '0;
  assign both_off = !POSITIVE_INPUT_SELECT &&
                    !NEGATIVE_INPUT_SELECT;
  assign kind_clash = POSITIVE_INPUT_SELECT && NEGATIVE_INPUT_SELECT &&
                      (POSITIVE_INPUT.kind != NEGATIVE_INPUT.kind);
  assign inhibit_w = both_off || kind_clash;
  assign kind_w = POSITIVE_INPUT_SELECT ? POSITIVE_INPUT.kind
                                        : NEGATIVE_INPUT.kind;

  // ****************************************************************
  // Operating signal
  // ****************************************************************
  logic signed [VW:0]    diff_w;
  logic signed [VW:0]    mag_w;
  logic signed [VW:0]    op_w;

  // Both operands fit in VW bits, so VW+1 cannot overflow
  assign diff_w = pos_v - neg_v;
  assign mag_w = diff_w[VW] ? -diff_w : diff_w;
  assign op_w = CFG.signed_or_magnitude_select ? mag_w : diff_w;

  // ****************************************************************
  // Rate interval timing
  // ****************************************************************
  logic [15:0]           ms_cnt_q;
  logic                  ms_tick_q;
  logic [15:0]           s_cnt_q;
  logic                  s_tick_q;
  logic [15:0]           min_cnt_q;
  logic                  min_tick_q;
  logic [15:0]           iv_cnt_q;
  logic                  unit_tick_w;
  logic                  iv_done_w;
  logic [15:0]           iv_len_w;
  logic                  rate_w;

  assign rate_w = CFG.level_or_rate_select;

  // Shared millisecond tick also drives the delay timers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ms_cnt_q <= 16'h0000;
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q >= 16'(MS_CYCLES - 1)) begin
      ms_cnt_q <= 16'h0000;
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
      ms_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s_cnt_q <= 16'h0000;
      s_tick_q <= 1'b0;
    end else begin
      s_tick_q <= 1'b0;
      if (ms_tick_q) begin
        if (s_cnt_q >= `ATC_MS_PER_S - 16'h0001) begin
          s_cnt_q <= 16'h0000;
          s_tick_q <= 1'b1;
        end else begin
          s_cnt_q <= s_cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      min_cnt_q <= 16'h0000;
      min_tick_q <= 1'b0;
    end else begin
      min_tick_q <= 1'b0;
      if (s_tick_q) begin
        if (min_cnt_q >= `ATC_S_PER_MIN - 16'h0001) begin
          min_cnt_q <= 16'h0000;
          min_tick_q <= 1'b1;
        end else begin
          min_cnt_q <= min_cnt_q + 16'h0001;
        end
      end
    end
  end

  assign unit_tick_w = (CFG.rate_interval_unit == ATC_UNIT_MIN) ?
                       min_tick_q :
                       (CFG.rate_interval_unit == ATC_UNIT_S) ?
                       s_tick_q : ms_tick_q;
  // A zero length would never sample; treat it as one unit
  assign iv_len_w = (CFG.rate_interval_length == 16'h0000) ?
                    16'h0001 : CFG.rate_interval_length;
  assign iv_done_w = unit_tick_w &&
                     (iv_cnt_q >= iv_len_w - 16'h0001);

  // Interval counter idles outside Delta mode
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      iv_cnt_q <= 16'h0000;
    end else if (!rate_w || iv_done_w) begin
      iv_cnt_q <= 16'h0000;
    end else if (unit_tick_w) begin
      iv_cnt_q <= iv_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Rate of change
  // ****************************************************************
  logic signed [VW:0]    sample_q;
  logic signed [VW+1:0]  delta_w;
  logic signed [VW+1:0]  sig_w;

  // Sample tracks the signal in Threshold mode, so Delta starts at zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sample_q <= '0;
    end else if (!rate_w || iv_done_w) begin
      sample_q <= op_w;
    end
  end

  assign delta_w = (VW+2)'(op_w) - (VW+2)'(sample_q);
  assign sig_w = rate_w ? delta_w : (VW+2)'(op_w);

  // ****************************************************************
  // Per-unit base and threshold
  // ****************************************************************
  logic [31:0]           pos_base;
  logic [31:0]           neg_base;
  logic [31:0]           max_base;
  logic [31:0]           base_w;
  logic signed [64:0]    prod_w;
  logic signed [CW-1:0]  thr_w;
  logic signed [CW-1:0]  thr_mag;
  logic [CW+7:0]         band_wide;
  logic signed [CW-1:0]  band_w;
  logic signed [CW-1:0]  sig_c;

  assign pos_base = POSITIVE_INPUT_SELECT ? POSITIVE_INPUT.base : '0;
  assign neg_base = NEGATIVE_INPUT_SELECT ? NEGATIVE_INPUT.base : '0;
  assign max_base = (pos_base > neg_base) ? pos_base
                                          : neg_base;

  always_comb begin
    case (kind_w)
      ATC_KIND_FREQ:   base_w = `ATC_FREQ_BASE;
      ATC_KIND_ANGLE:  base_w = `ATC_ANGLE_BASE;
      ATC_KIND_ENERGY: base_w = `ATC_ENERGY_BASE;
      ATC_KIND_TEMP:   base_w = `ATC_TEMP_BASE;
      default:         base_w = max_base;
    endcase
  end

  // Pickup is signed per-unit with FR fraction bits
  assign prod_w = CFG.pickup_threshold * $signed({1'b0, base_w});
  assign thr_w = CW'(prod_w >>> FR);
  assign thr_mag = thr_w[CW-1] ? -thr_w : thr_w;
  assign band_wide = (CW+8)'(thr_mag) * (CW+8)'(CFG.dropout_band_percent)
                     / (CW+8)'(`ATC_PCT_DIV);
  assign band_w = $signed(band_wide[CW-1:0]);
  assign sig_c = CW'(sig_w);

  // ****************************************************************
  // Pickup and dropout comparison
  // ****************************************************************
  logic                  over_pk;
  logic                  over_drop;
  logic                  under_pk;
  logic                  under_drop;
  logic                  pk_w;
  logic                  drop_w;
  logic                  cond_q;

  assign over_pk = sig_c > thr_w;
  assign over_drop = sig_c < (thr_w - band_w);
  assign under_pk = sig_c < thr_w;
  assign under_drop = sig_c > (thr_w + band_w);
  assign pk_w = CFG.over_under_select ? under_pk : over_pk;
  assign drop_w = CFG.over_under_select ? under_drop : over_drop;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cond_q <= 1'b0;
    end else if (inhibit_w) begin
      cond_q <= 1'b0;
    end else if (!cond_q && pk_w) begin
      cond_q <= 1'b1;
    end else if (cond_q && drop_w) begin
      cond_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Pickup and reset delays
  // ****************************************************************
  logic [16:0]           tmr_q;
  logic                  flag_q;
  logic                  inh_q;
  logic [15:0]           dly_w;
  logic                  expire_w;

  assign dly_w = cond_q ? CFG.assert_delay : CFG.deassert_delay;
  // The ms tick free-runs, so its first tick may come at once; one
  // extra tick keeps a delay from running short of its setting
  assign expire_w = (dly_w == 16'h0000) ||
                    (tmr_q > {1'b0, dly_w});

  // Timer runs only while condition and flag disagree
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tmr_q <= 17'h0_0000;
      flag_q <= 1'b0;
    end else if (inhibit_w) begin
      tmr_q <= 17'h0_0000;
      flag_q <= 1'b0;
    end else if (cond_q == flag_q) begin
      tmr_q <= 17'h0_0000;
    end else if (expire_w) begin
      tmr_q <= 17'h0_0000;
      flag_q <= cond_q;
    end else if (ms_tick_q) begin
      tmr_q <= tmr_q + 17'h0_0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      inh_q <= 1'b0;
    end else begin
      inh_q <= inhibit_w;
    end
  end

  assign FLAG = flag_q;
  assign PICKUP = cond_q;
  assign INHIBITED = inh_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_NO_INPUT: assert property (
    @(posedge CLK) disable iff (!RST_B)
    both_off |=> !flag_q && !cond_q)
    else $error("Flag set with no input selected");

  AST_KIND_CLASH: assert property (
    @(posedge CLK) disable iff (!RST_B)
    kind_clash |=> !flag_q && !cond_q)
    else $error("Flag set with unlike input kinds");

  AST_OFF_ZERO: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!POSITIVE_INPUT_SELECT && NEGATIVE_INPUT_SELECT &&
     !CFG.signed_or_magnitude_select)
    |-> diff_w == -(VW+1)'(NEGATIVE_INPUT.value))
    else $error("Off input not taken as zero");

  AST_ABS_MODE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    CFG.signed_or_magnitude_select |-> !op_w[VW])
    else $error("Absolute mode gave negative signal");

  AST_RATE_SAMPLE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    rate_w && iv_done_w |=> sample_q == $past(op_w))
    else $error("Interval sample not taken");

  AST_OVER_PICKUP: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !inhibit_w && !CFG.over_under_select && !cond_q && over_pk
    |=> cond_q)
    else $error("Over pickup missed");

  AST_HOLD_BAND: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !inhibit_w && !CFG.over_under_select && cond_q && !over_drop
    |=> cond_q)
    else $error("Dropped out inside hysteresis band");

  AST_PKP_DELAY: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $rose(flag_q) |-> $past(cond_q) &&
                      $past(tmr_q) >= 17'($past(CFG.assert_delay)))
    else $error("Flag rose before pickup delay");

  AST_RST_DELAY: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $fell(flag_q) && !$past(inhibit_w) |->
      !$past(cond_q) && $past(tmr_q) >= 17'($past(CFG.deassert_delay)))
    else $error("Flag fell before reset delay");

  AST_RESTART: assert property (
    @(posedge CLK) disable iff (!RST_B)
    cond_q == flag_q |=> tmr_q == 17'h0_0000)
    else $error("Delay timer not restarted");

endmodule

// ===== atc_comparator_tb_top.sv
`timescale 1ns/10ps

module atc_comparator_tb_top
  import atc_pkg::*;
;

  // ****************************************************************
  // Stimulus table
  // ****************************************************************
  typedef struct packed {
    logic               ps;
    logic               ns;
    atc_kind_t          pk;
    atc_kind_t          nk;
    logic        [15:0] pb;
    logic        [15:0] nb;
    logic signed [15:0] pv;
    logic signed [15:0] nv;
    logic               ab;
    logic               un;
    logic signed [15:0] pu;
    logic               ep;
    logic               ei;
  } atc_row_t;

  localparam atc_kind_t          kv = ATC_KIND_VOLT;
  localparam atc_kind_t          kc = ATC_KIND_CURR;
  localparam atc_kind_t          kd = ATC_KIND_DCMA;
  localparam atc_kind_t          kf = ATC_KIND_FREQ;
  localparam atc_kind_t          ka = ATC_KIND_ANGLE;
  localparam atc_kind_t          ke = ATC_KIND_ENERGY;
  localparam atc_kind_t          kt = ATC_KIND_TEMP;
  localparam logic        [15:0] b1 = 16'h03E8;
  localparam logic        [15:0] b5 = 16'h0005;
  localparam logic        [15:0] z  = 16'h0000;
  localparam logic signed [15:0] p1 = 16'sh1000;

  // Fixed-base rows carry a bogus base that must be ignored
  localparam atc_row_t rows [22] = '{
    '{1,0,kv,kv,b1,b1,16'h03E9,z,0,0,p1,1,0},
    '{1,0,kv,kv,b1,b1,16'h03B6,z,0,0,p1,1,0},
    '{1,0,kv,kv,b1,b1,16'h0383,z,0,0,p1,0,0},
    '{1,1,kv,kv,b1,b1,16'h0BB8,16'h07CF,0,0,p1,1,0},
    '{0,1,kv,kv,b1,b1,-16'sh0BB8,-16'sh05DC,0,0,p1,1,0},
    '{0,0,kv,kv,b1,b1,16'h0BB8,z,0,0,p1,0,1},
    '{1,1,kv,kf,b1,b1,16'h0BB8,z,0,0,p1,0,1},
    '{0,1,kv,kv,b1,b1,z,16'h04B0,1,0,p1,1,0},
    '{0,1,kv,kv,b1,b1,z,16'h04B0,0,0,p1,0,0},
    '{1,0,kv,kv,b1,b1,-16'sh04B0,z,0,1,-p1,1,0},
    '{1,0,kv,kv,b1,b1,-16'sh03B6,z,0,1,-p1,1,0},
    '{1,0,kv,kv,b1,b1,-16'sh0352,z,0,1,-p1,0,0},
    '{1,0,ka,ka,b5,b1,16'h0E0F,z,0,0,p1,0,0},
    '{1,0,ka,ka,b5,b1,16'h0E11,z,0,0,p1,1,0},
    '{1,0,kf,kf,b5,b1,16'h0383,z,0,0,p1,0,0},
    '{1,0,kf,kf,b5,b1,16'h03E9,z,0,0,p1,1,0},
    '{1,0,kt,kt,b5,b1,16'h0383,z,0,0,p1,0,0},
    '{1,0,ke,ke,b5,b1,16'h2711,z,0,0,p1,1,0},
    '{1,0,ke,ke,b5,b1,16'h2327,z,0,0,p1,0,0},
    '{1,1,kd,kd,16'h01F4,16'h07D0,16'h07D1,z,0,0,p1,1,0},
    '{1,1,kc,kc,16'h07D0,16'h01F4,16'h079E,z,0,0,p1,1,0},
    '{1,1,kc,kc,16'h07D0,16'h01F4,16'h0707,z,0,0,p1,0,0}
  };

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic      CLK;
  logic      RST_B;
  logic      p_sel;
  logic      n_sel;
  atc_meas_t p_req;
  atc_meas_t n_req;
  atc_meas_t p_meas;
  atc_meas_t n_meas;
  atc_cfg_t  cfg;
  logic      flag;
  logic      pickup;
  logic      inhibited;
  int        err_total;
  int        checks;
  int        n;

  initial CLK = 1'b0;
  always #12.5 CLK = ~CLK;

  atc_meas_model u_pos (.clk(CLK), .rst_b(RST_B), .sel(p_sel),
                        .req(p_req), .meas(p_meas));
  atc_meas_model u_neg (.clk(CLK), .rst_b(RST_B), .sel(n_sel),
                        .req(n_req), .meas(n_meas));

  // Short ms tick keeps the delay tests to tens of cycles
  atc_comparator #(.MS_CYCLES(4)) DUT (
    .CLK                   (CLK),
    .RST_B                 (RST_B),
    .POSITIVE_INPUT_SELECT (p_sel),
    .POSITIVE_INPUT        (p_meas),
    .NEGATIVE_INPUT_SELECT (n_sel),
    .NEGATIVE_INPUT        (n_meas),
    .CFG                   (cfg),
    .FLAG                  (flag),
    .PICKUP                (pickup),
    .INHIBITED             (inhibited)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic put(input atc_row_t x);
    @(posedge CLK);
    p_sel <= x.ps;
    n_sel <= x.ns;
    p_req <= '{x.pk, 32'(x.pb), 32'(x.pv)};
    n_req <= '{x.nk, 32'(x.nb), 32'(x.nv)};
    cfg.signed_or_magnitude_select <= x.ab;
    cfg.over_under_select <= x.un;
    cfg.pickup_threshold <= 32'(x.pu);
  endtask

  task automatic set_pv(input logic signed [15:0] v);
    @(posedge CLK);
    p_req.value <= 32'(v);
  endtask

  // Bounded wait on PICKUP (f=0) or FLAG (f=1)
  task automatic waitv(input logic f, input logic v, output int c);
    c = 0;
    #1;
    while (((f ? flag : pickup) !== v) && c < 60) begin
      @(posedge CLK);
      #1;
      c++;
    end
    if (c >= 60) begin
      chk(32'(c), 32'h0000_0000);
    end
  endtask

  task automatic results();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge CLK);
    err_total++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    RST_B = 1'b0;
    p_sel = 1'b0;
    n_sel = 1'b0;
    p_req = '0;
    n_req = '0;
    err_total = 0;
    checks = 0;
    cfg = '0;
    cfg.dropout_band_percent = 8'h0A;
    cfg.rate_interval_unit = ATC_UNIT_MIN;
    repeat (12) @(posedge CLK);
    RST_B <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i]);
      repeat (5) @(posedge CLK);
      #1;
      chk(pickup, rows[i].ep);
      chk(flag, rows[i].ep);
      chk(inhibited, rows[i].ei);
    end
    // Delays, with a pickup cut short first
    put('{1,0,kv,kv,b1,b1,16'h0383,z,0,0,p1,0,0});
    @(posedge CLK);
    cfg.assert_delay <= 16'h0002;
    cfg.deassert_delay <= 16'h0002;
    repeat (4) @(posedge CLK);
    set_pv(16'h03E9);
    waitv(0, 1, n);
    repeat (2) @(posedge CLK);
    set_pv(16'h0383);
    waitv(0, 0, n);
    chk(flag, 1'b0);
    set_pv(16'h03E9);
    waitv(0, 1, n);
    waitv(1, 1, n);
    chk(n >= 8 && n <= 13, 1'b1);
    set_pv(16'h0383);
    waitv(0, 0, n);
    waitv(1, 0, n);
    chk(n >= 8 && n <= 13, 1'b1);
    // Rate of change over a 2 ms interval
    @(posedge CLK);
    cfg.assert_delay <= 16'h0000;
    cfg.deassert_delay <= 16'h0000;
    cfg.level_or_rate_select <= 1'b1;
    cfg.rate_interval_unit <= ATC_UNIT_MS;
    cfg.rate_interval_length <= 16'h0002;
    set_pv(16'h0000);
    repeat (20) @(posedge CLK);
    set_pv(16'h03E9);
    waitv(0, 1, n);
    chk(n <= 12, 1'b1);
    waitv(0, 0, n);
    chk(n >= 1 && n <= 10, 1'b1);
    set_pv(16'h05DC);
    repeat (12) @(posedge CLK);
    #1;
    chk(pickup, 1'b0);
    // Back to level mode, then a reset in mid-run
    @(posedge CLK);
    cfg.level_or_rate_select <= 1'b0;
    repeat (5) @(posedge CLK);
    #1;
    chk({flag, pickup}, 2'b11);
    @(posedge CLK);
    RST_B <= 1'b0;
    @(posedge CLK);
    #1;
    chk({flag, pickup, inhibited}, 3'b000);
    @(posedge CLK);
    RST_B <= 1'b1;
    // Engine output restarts from zero, so pickup needs one more edge
    @(posedge CLK);
    #1;
    chk({flag, pickup, inhibited}, 3'b000);
    repeat (2) @(posedge CLK);
    #1;
    chk({flag, pickup}, 2'b11);
    results();
  end

endmodule

// ===== atc_map.svh
// Function
// - Operating signal is positive minus negative input
// - Input selected Off contributes zero
// - Both inputs Off never asserts the flag
// - Inputs of unlike kinds inhibit the element
// - Signed uses difference, Absolute uses its magnitude
// - Threshold compares level, Delta compares rate
// - Interval settings matter only in Delta mode
// - Rate taken over interval length in unit
// - Direction selects response to high or low
// - Over picks up above, Under below threshold
// - Signal and threshold are both signed
// - Hysteresis band is percent of pickup
// - Current, voltage base is larger input nominal
// - Frequency base 1 Hz, angle 360 degrees
// - Energy base 10000 MWh, temperature 100 C
// - Transducer base is larger configured range maximum
// - Flag asserts after pickup delay
// - Flag clears after reset delay
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// ****************************************************************
// Widths and scaling
// ****************************************************************
`define ATC_VAL_W        32
`define ATC_PU_FRAC      12
`define ATC_PCT_DIV      8'h64

// Fixed bases in native counts: mHz, 0.1 deg, MWh, 0.1 C
`define ATC_FREQ_BASE    32'h0000_03E8
`define ATC_ANGLE_BASE   32'h0000_0E10
`define ATC_ENERGY_BASE  32'h0000_2710
`define ATC_TEMP_BASE    32'h0000_03E8

// ****************************************************************
// Timing
// ****************************************************************
`define ATC_CLK_NS       32'h0000_0019
`define ATC_MS_NS        32'h000F_4240
`define ATC_MS_CYCLES    (`ATC_MS_NS / `ATC_CLK_NS)
`define ATC_MS_PER_S     16'h03E8
`define ATC_S_PER_MIN    16'h003C

`endif

// ===== atc_meas_model.sv
`timescale 1ns/10ps

module atc_meas_model
  import atc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_b,
  // Requested quantity
  input  wire logic      sel,
  input  wire atc_meas_t req,
  // Presented quantity
  output atc_meas_t      meas
);

  // ****************************************************************
  // Engine output
  // ****************************************************************
  // An unselected channel keeps churning, so a leak of it cannot hide
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meas <= '0;
    end else if (sel) begin
      meas <= req;
    end else begin
      meas.value <= ~meas.value;
    end
  end

endmodule

// ===== atc_pkg.sv
package atc_pkg;

  typedef enum logic [2:0] {
    ATC_KIND_CURR,
    ATC_KIND_VOLT,
    ATC_KIND_DCMA,
    ATC_KIND_FREQ,
    ATC_KIND_ANGLE,
    ATC_KIND_ENERGY,
    ATC_KIND_TEMP,
    ATC_KIND_OTHER
  } atc_kind_t;

  typedef enum logic [1:0] {
    ATC_UNIT_MS,
    ATC_UNIT_S,
    ATC_UNIT_MIN
  } atc_unit_t;

  // One measured quantity from the measurement engine
  typedef struct packed {
    atc_kind_t                 kind;
    logic [31:0]               base;
    logic signed [31:0]        value;
  } atc_meas_t;

  typedef struct packed {
    logic                      signed_or_magnitude_select;
    logic                      level_or_rate_select;
    logic                      over_under_select;
    logic signed [31:0]        pickup_threshold;
    logic [7:0]                dropout_band_percent;
    atc_unit_t                 rate_interval_unit;
    logic [15:0]               rate_interval_length;
    logic [15:0]               assert_delay;
    logic [15:0]               deassert_delay;
  } atc_cfg_t;

endpackage
